// File: bhc_pkg.sv
// constants, lookup tables and state codes of the boost/headroom
// configuration register bank; assumes one 10 MHz clock and sync reset
// Operation
// R1 - answers at 2Ch, or 2Eh when alternate selected
// R2 - halve bit picks reduced peak current limits
// R3 - two-bit code selects one of four limits
// R4 - divisor code encodes four modulation ratios
// R5 - modulation rate follows boost switching frequency
// R6 - slope code sets headroom at 50 mA
// R7 - minimum headroom from 50 mV, 30 mV steps
// R8 - hysteresis code sets mid comparator threshold
// R9 - range code selects fraction of driver range
// R10 - slew code acts only while limit enabled
// R11 - reserved bits read zero, fields read back; only 78h and 79h mask bits, 76h and 77h store all eight bits
package bhc_pkg;

   localparam int NREG = 4;

   // target addresses, 7 bit
   localparam logic [6:0] ADDR_PRIMARY   = 7'h2c;
   localparam logic [6:0] ADDR_ALTERNATE = 7'h2e;

   // register offsets
   localparam logic [7:0] OFS_BOOST_LIMIT = 8'h76;
   localparam logic [7:0] OFS_SPREAD      = 8'h77;
   localparam logic [7:0] OFS_SLOPE_MIN   = 8'h78;
   localparam logic [7:0] OFS_HYST_RANGE  = 8'h79;
   localparam logic [NREG-1:0][7:0] REG_OFFSETS =
      {OFS_HYST_RANGE, OFS_SLOPE_MIN, OFS_SPREAD, OFS_BOOST_LIMIT};
   // writable bits; the rest read as zero
   localparam logic [NREG-1:0][7:0] REG_WMASK =
      {8'h33, 8'h77, 8'hff, 8'hff};
   localparam logic [7:0] REG_RESET = 8'h00;

   localparam int IDX_BOOST_LIMIT = 0;
   localparam int IDX_SPREAD      = 1;
   localparam int IDX_SLOPE_MIN   = 2;
   localparam int IDX_HYST_RANGE  = 3;

   // field positions
   localparam int POS_HALVE    = 7;
   localparam int POS_ALT_ADDR = 4;
   localparam int POS_SLEW     = 2;
   localparam int POS_LIMIT    = 0;
   localparam int POS_MODDIV   = 6;
   localparam int POS_SLOPE    = 4;
   localparam int POS_MINHR    = 0;
   localparam int POS_HYST     = 4;
   localparam int POS_RANGE    = 0;

   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // peak limit in mA: normal and halved sets
   localparam logic [3:0][11:0] PEAK_MA_NORMAL =
      {12'hc1c, 12'ha28, 12'h834, 12'h60e};
   localparam logic [3:0][11:0] PEAK_MA_HALVED =
      {12'h708, 12'h5dc, 12'h4b0, 12'h384};
   // headroom at 50 mA, mV
   localparam logic [7:0][8:0] SLOPE_MV =
      {9'h12c, 9'h11d, 9'h111, 9'h104, 9'h0f8, 9'h0eb, 9'h0df, 9'h0d2};
   // minimum headroom, mV
   localparam logic [7:0][8:0] MINHR_MV =
      {9'h104, 9'h0e6, 9'h0c8, 9'h0aa, 9'h08c, 9'h06e, 9'h050, 9'h032};
   // mid threshold above low threshold, mV
   localparam logic [3:0][9:0] HYST_MV =
      {10'h258, 10'h1d2, 10'h0e9, 10'h0c8};
   // driver range in tenths of a percent
   localparam logic [3:0][8:0] RANGE_PERMILLE =
      {9'h1f4, 9'h177, 9'h0fa, 9'h00a};
   // modulation period in boost cycles (1000 kHz / 4.17 kHz etc)
   localparam logic [3:0][9:0] MOD_PERIOD =
      {10'h348, 10'h258, 10'h168, 10'h0f0};

   typedef enum logic [6:0] {
      ST_IDLE     = 7'h01,
      ST_ADDR     = 7'h02,
      ST_ADDR_ACK = 7'h04,
      ST_RX       = 7'h08,
      ST_RX_ACK   = 7'h10,
      ST_TX       = 7'h20,
      ST_TX_ACK   = 7'h40
   } bhc_state_t;

endpackage

// File: bhc_reg_file.sv
// four configuration registers with masked write and registered read
// assumes write strobe and address come from the serial target logic
`timescale 1ns/1ps
module bhc_reg_file
   import bhc_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  wr_en,
   input  wire logic [7:0]            addr,
   input  wire logic [7:0]            wr_data,
   output logic      [7:0]            rd_data,
   output logic      [NREG-1:0][7:0]  regs
);
   logic [7:0] regs_q [NREG];
   logic [7:0] regs_d [NREG];
   logic [7:0] rd_d;
   logic [7:0] rd_q;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_reg
         always_comb begin
            regs_d[gi] = regs_q[gi];
            if (wr_en && addr == REG_OFFSETS[gi]) begin
               regs_d[gi] = wr_data & REG_WMASK[gi]; // R11
            end
         end
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               regs_q[gi] <= REG_RESET;
            end else begin
               regs_q[gi] <= regs_d[gi];
            end
         end
         assign regs[gi] = regs_q[gi];
      end
   endgenerate

   // unmapped offsets read zero
   always_comb begin
      rd_d = 8'h00;
      for (int i = 0; i < NREG; i++) begin
         if (addr == REG_OFFSETS[i]) begin
            rd_d = regs_q[i];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_q <= 8'h00;
      end else begin
         rd_q <= rd_d;
      end
   end

   assign rd_data = rd_q;

   reserved_zero_a: assert property ( // R11
      (regs_q[IDX_SLOPE_MIN] & ~REG_WMASK[IDX_SLOPE_MIN]) == 8'h00 &&
      (regs_q[IDX_HYST_RANGE] & ~REG_WMASK[IDX_HYST_RANGE]) == 8'h00)
      else $error("reserved register bits not zero");

   write_readback_a: assert property ( // R11
      wr_en && addr == OFS_SPREAD
      |=> regs_q[IDX_SPREAD] == $past(wr_data))
      else $error("written byte not stored");
endmodule

// File: bhc_config_regs.sv
// serial target with register pointer, plus decode of the boost and
// headroom configuration fields; scl/sda are synchronous to sys_clk
// and scl stays high or low for at least two clock cycles
`timescale 1ns/1ps
module bhc_config_regs
   import bhc_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   input  wire logic        slew_limit_enable,
   input  wire logic        boost_tick,
   output logic [11:0]      peak_limit_ma,
   output logic [1:0]       slowed_slew_code,
   output logic             modulation_tick,
   output logic [8:0]       headroom_slope_mv,
   output logic [8:0]       minimum_headroom_mv,
   output logic [9:0]       mid_threshold_mv,
   output logic [8:0]       horizontal_range_permille
);
   bhc_state_t           state_q, state_d;
   logic [3:0]           cnt_q, cnt_d;
   logic [7:0]           shift_q, shift_d;
   logic [7:0]           ptr_q, ptr_d;
   logic                 rw_q, rw_d;
   logic                 pend_q, pend_d;
   logic                 oe_q, oe_d;
   logic                 scl_q, sda_q;
   logic                 wr_en;
   logic [7:0]           rd_data;
   logic [NREG-1:0][7:0] regs;
   logic [6:0]           target_addr;
   logic                 scl_rise, scl_fall, start_seen, stop_seen;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   bhc_reg_file u_regs (
      .sys_clk (sys_clk),
      .rst     (rst),
      .wr_en   (wr_en),
      .addr    (ptr_q),
      .wr_data (shift_q),
      .rd_data (rd_data),
      .regs    (regs)
   );

   // field views
   logic       current_limit_halve_select;
   logic       alternate_target_address;
   logic [1:0] peak_limit_code;
   logic [1:0] slew_code_raw;
   logic [1:0] modulation_divisor;
   logic [2:0] headroom_slope_code;
   logic [2:0] minimum_headroom_code;
   logic [1:0] mid_threshold_hysteresis;
   logic [1:0] horizontal_range_code;

   assign current_limit_halve_select = regs[IDX_BOOST_LIMIT][POS_HALVE];
   assign alternate_target_address   = regs[IDX_BOOST_LIMIT][POS_ALT_ADDR];
   assign peak_limit_code       = regs[IDX_BOOST_LIMIT][POS_LIMIT +: 2];
   assign slew_code_raw         = regs[IDX_BOOST_LIMIT][POS_SLEW +: 2];
   assign modulation_divisor    = regs[IDX_SPREAD][POS_MODDIV +: 2];
   assign headroom_slope_code   = regs[IDX_SLOPE_MIN][POS_SLOPE +: 3];
   assign minimum_headroom_code = regs[IDX_SLOPE_MIN][POS_MINHR +: 3];
   assign mid_threshold_hysteresis = regs[IDX_HYST_RANGE][POS_HYST +: 2];
   assign horizontal_range_code = regs[IDX_HYST_RANGE][POS_RANGE +: 2];

   // bus condition detection
   assign scl_rise   = scl_i & ~scl_q;
   assign scl_fall   = ~scl_i & scl_q;
   assign start_seen = scl_i & scl_q & sda_q & ~sda_i;
   assign stop_seen  = scl_i & scl_q & ~sda_q & sda_i;

   assign target_addr = alternate_target_address ? ADDR_ALTERNATE
                                                 : ADDR_PRIMARY; // R1

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      shift_d = shift_q;
      ptr_d   = ptr_q;
      rw_d    = rw_q;
      pend_d  = pend_q;
      oe_d    = oe_q;
      wr_en   = 1'b0;
      if (start_seen) begin
         state_d = ST_ADDR;
         cnt_d   = 4'h0;
         oe_d    = 1'b0;
      end else if (stop_seen) begin
         state_d = ST_IDLE;
         oe_d    = 1'b0;
      end else begin
         case (state_q)
            ST_ADDR: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], sda_i};
                  cnt_d   = cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                  if (shift_q[7:1] == target_addr) begin // R1
                     oe_d    = 1'b1;
                     rw_d    = shift_q[0];
                     state_d = ST_ADDR_ACK;
                  end else begin
                     state_d = ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  cnt_d = 4'h0;
                  if (rw_q) begin
                     shift_d = rd_data;
                     oe_d    = ~rd_data[7];
                     state_d = ST_TX;
                  end else begin
                     oe_d    = 1'b0;
                     pend_d  = 1'b1;
                     state_d = ST_RX;
                  end
               end
            end
            ST_RX: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], sda_i};
                  cnt_d   = cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                  oe_d    = 1'b1;
                  state_d = ST_RX_ACK;
                  if (pend_q) begin
                     ptr_d  = shift_q;
                     pend_d = 1'b0;
                  end else begin
                     wr_en = 1'b1;
                     ptr_d = ptr_q + 8'h01;
                  end
               end
            end
            ST_RX_ACK: begin
               if (scl_fall) begin
                  oe_d    = 1'b0;
                  cnt_d   = 4'h0;
                  state_d = ST_RX;
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == BITS_PER_BYTE - 4'h1) begin
                     oe_d    = 1'b0;
                     state_d = ST_TX_ACK;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     oe_d    = ~shift_q[6];
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  if (sda_i) begin
                     state_d = ST_IDLE;
                  end else begin
                     ptr_d = ptr_q + 8'h01;
                  end
               end else if (scl_fall) begin
                  cnt_d   = 4'h0;
                  shift_d = rd_data;
                  oe_d    = ~rd_data[7];
                  state_d = ST_TX;
               end
            end
            ST_IDLE: begin
               oe_d = 1'b0;
            end
            default: begin
               state_d = ST_IDLE;
               oe_d    = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         cnt_q   <= 4'h0;
         shift_q <= 8'h00;
         ptr_q   <= 8'h00;
         rw_q    <= 1'b0;
         pend_q  <= 1'b0;
         oe_q    <= 1'b0;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         ptr_q   <= ptr_d;
         rw_q    <= rw_d;
         pend_q  <= pend_d;
         oe_q    <= oe_d;
         scl_q   <= scl_i;
         sda_q   <= sda_i;
      end
   end

   assign sda_o  = 1'b0;
   assign sda_oe = oe_q;

   // decoded configuration values
   logic [11:0] peak_d;
   logic [1:0]  slew_d;
   logic [9:0]  mod_cnt_q, mod_cnt_d, mod_period;
   logic        mod_tick_d;

   always_comb begin
      peak_d = current_limit_halve_select
             ? PEAK_MA_HALVED[peak_limit_code]     // R2
             : PEAK_MA_NORMAL[peak_limit_code];    // R3
      slew_d = slew_limit_enable ? slew_code_raw : 2'b00; // R10
      mod_period = MOD_PERIOD[modulation_divisor];        // R4
      mod_cnt_d  = mod_cnt_q;
      mod_tick_d = 1'b0;
      if (boost_tick) begin
         if (mod_cnt_q >= mod_period - 10'h001) begin // R5
            mod_cnt_d  = 10'h000;
            mod_tick_d = 1'b1;
         end else begin
            mod_cnt_d = mod_cnt_q + 10'h001;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         peak_limit_ma             <= 12'h000;
         slowed_slew_code          <= 2'b00;
         modulation_tick           <= 1'b0;
         mod_cnt_q                 <= 10'h000;
         headroom_slope_mv         <= 9'h000;
         minimum_headroom_mv       <= 9'h000;
         mid_threshold_mv          <= 10'h000;
         horizontal_range_permille <= 9'h000;
      end else begin
         peak_limit_ma       <= peak_d;
         slowed_slew_code    <= slew_d;
         modulation_tick     <= mod_tick_d;
         mod_cnt_q           <= mod_cnt_d;
         headroom_slope_mv   <= SLOPE_MV[headroom_slope_code];    // R6
         minimum_headroom_mv <= MINHR_MV[minimum_headroom_code];  // R7
         mid_threshold_mv    <= HYST_MV[mid_threshold_hysteresis]; // R8
         horizontal_range_permille <=
            RANGE_PERMILLE[horizontal_range_code];                // R9
      end
   end

   addr_ack_a: assert property ( // R1
      state_q == ST_ADDR && scl_fall && cnt_q == BITS_PER_BYTE &&
      !start_seen && !stop_seen && shift_q[7:1] ==
      (alternate_target_address ? 7'h2e : 7'h2c)
      |=> sda_oe && state_q == ST_ADDR_ACK)
      else $error("matching address not acknowledged");

   addr_ignore_a: assert property ( // R1
      state_q == ST_ADDR && scl_fall && cnt_q == BITS_PER_BYTE &&
      !start_seen && !stop_seen && shift_q[7:1] != target_addr
      |=> !sda_oe && state_q == ST_IDLE)
      else $error("foreign address acknowledged");

   halved_limit_a: assert property ( // R2
      current_limit_halve_select && peak_limit_code == 2'b11
      |=> peak_limit_ma == 12'h708)
      else $error("halved limit not 1.8 A");

   normal_limit_a: assert property ( // R3
      !current_limit_halve_select && peak_limit_code == 2'b00
      |=> peak_limit_ma == 12'h60e)
      else $error("normal limit code 0 not 1.55 A");

   mod_spacing_a: assert property ( // R5
      modulation_tick && modulation_divisor == 2'b00 &&
      $stable(modulation_divisor)
      |-> mod_cnt_q == 10'h000 && $past(mod_cnt_q) == 10'h0ef)
      else $error("modulation period wrong for code 0");

   slope_top_a: assert property ( // R6
      headroom_slope_code == 3'h7 |=> headroom_slope_mv == 9'h12c)
      else $error("slope code 7 not 300 mV");

   min_step_a: assert property ( // R7
      minimum_headroom_code == 3'h1 ##1 minimum_headroom_code == 3'h2
      |=> minimum_headroom_mv == $past(minimum_headroom_mv) + 9'h01e)
      else $error("minimum headroom step not 30 mV");

   hyst_value_a: assert property ( // R8
      mid_threshold_hysteresis == 2'b10 |=> mid_threshold_mv == 10'h1d2)
      else $error("hysteresis code 2 not 466 mV");

   range_value_a: assert property ( // R9
      horizontal_range_code == 2'b00 |=> horizontal_range_permille == 9'h00a)
      else $error("range code 0 not 1 percent");

   slew_gate_a: assert property ( // R10
      !slew_limit_enable |=> slowed_slew_code == 2'b00)
      else $error("slew code active without enable");
endmodule

// File: bhc_i2c_host.sv
// serial bus host model: start, stop, byte write and byte read
// assumes sda_line is the wired-and of host and target, pulled up
`timescale 1ns/1ps
module bhc_i2c_host (
   input  wire logic sys_clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   localparam int HALF = 4;

   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic hold();
      repeat (HALF) @(posedge sys_clk);
   endtask

   // also a repeated start when entered with scl low
   task automatic start_c();
      @(posedge sys_clk) sda_drv <= 1'b1;
      hold();
      scl <= 1'b1;
      hold();
      sda_drv <= 1'b0;
      hold();
      scl <= 1'b0;
   endtask

   task automatic stop_c();
      @(posedge sys_clk) sda_drv <= 1'b0;
      hold();
      scl <= 1'b1;
      hold();
      sda_drv <= 1'b1;
      hold();
   endtask

   // sda moves only while scl is low
   task automatic bit_c(input logic b, output logic r);
      @(posedge sys_clk) sda_drv <= b;
      hold();
      scl <= 1'b1;
      hold();
      r = sda_line;
      scl <= 1'b0;
   endtask

   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_c(d[i], r);
      bit_c(1'b1, r);
      ack = ~r;
   endtask

   task automatic get_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_c(1'b1, r);
         d[i] = r;
      end
      bit_c(last, r);
   endtask
endmodule

// File: tb_top.sv
// self-checking bench for the boost and headroom register bank
// assumes an open-drain sda with pull-up, host model on the far side
`timescale 1ns/1ps
module tb_top;
   localparam int LIMIT = 80000;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        slew_limit_enable = 1'b0;
   logic        boost_tick = 1'b0;
   logic        scl, sda_drv, sda_o, sda_oe, modulation_tick;
   logic [11:0] peak_limit_ma;
   logic [1:0]  slowed_slew_code;
   logic [8:0]  headroom_slope_mv, minimum_headroom_mv;
   logic [9:0]  mid_threshold_mv;
   logic [8:0]  horizontal_range_permille;
   wire         sda_line = sda_drv & ~(sda_oe & ~sda_o);
   int          err_count = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          mod_cnt = 0;
   int pk_n [4] = '{1550, 2100, 2600, 3100};
   int pk_h [4] = '{900, 1200, 1500, 1800};
   int slope [8] = '{210, 223, 235, 248, 260, 273, 285, 300};
   int hyst [4] = '{200, 233, 466, 600};
   int range [4] = '{10, 250, 375, 500};
   int period [4] = '{240, 360, 600, 840};

   bhc_config_regs bhc_config_regs_i (
      .sys_clk(sys_clk), .rst(rst), .scl_i(scl), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe(sda_oe),
      .slew_limit_enable(slew_limit_enable), .boost_tick(boost_tick),
      .peak_limit_ma(peak_limit_ma), .slowed_slew_code(slowed_slew_code),
      .modulation_tick(modulation_tick),
      .headroom_slope_mv(headroom_slope_mv),
      .minimum_headroom_mv(minimum_headroom_mv),
      .mid_threshold_mv(mid_threshold_mv),
      .horizontal_range_permille(horizontal_range_permille));
   bhc_i2c_host host_i (.sys_clk(sys_clk), .sda_line(sda_line),
      .scl(scl), .sda_drv(sda_drv));

   always #50 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (!rst && modulation_tick === 1'b1)
         mod_cnt <= mod_cnt + 1;
      if (cyc == LIMIT) begin
         err_count++;
         $display("[FAIL] cycle_limit expected %0d seen %0d", LIMIT, cyc);
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [6:0] dev, input logic [7:0] ofs,
                     input logic [31:0] d, input int n, output logic ack);
      logic a;
      host_i.start_c();
      host_i.put_byte({dev, 1'b0}, ack);
      host_i.put_byte(ofs, a);
      for (int k = 0; k < n; k++)
         host_i.put_byte(d[31-8*k -: 8], a);
      host_i.stop_c();
   endtask

   task automatic rd(input logic [6:0] dev, input logic [7:0] ofs,
                     input int n, output logic [31:0] q);
      logic a;
      logic [7:0] b;
      q = 32'h0;
      host_i.start_c();
      host_i.put_byte({dev, 1'b0}, a);
      host_i.put_byte(ofs, a);
      host_i.start_c();
      host_i.put_byte({dev, 1'b1}, a);
      for (int k = 0; k < n; k++) begin
         host_i.get_byte(k == n - 1, b);
         q = {q[23:0], b};
      end
      host_i.stop_c();
   endtask

   task automatic put(input logic [7:0] ofs, input logic [7:0] v);
      logic a;
      wr(7'h2c, ofs, {v, 24'h0}, 1, a);
      chk("ack_2c", a, 1'b1);
   endtask

   task automatic outs(input int pk, sl, mh, hy, rg);
      chk("peak", peak_limit_ma, pk);
      chk("slope", headroom_slope_mv, sl);
      chk("minhr", minimum_headroom_mv, mh);
      chk("hyst", mid_threshold_mv, hy);
      chk("range", horizontal_range_permille, rg);
   endtask

   task automatic t_reset();
      logic [31:0] q;
      outs(1550, 210, 50, 200, 10);
      chk("slew", slowed_slew_code, 2'h0);
      rd(7'h2c, 8'h76, 4, q);
      chk("reset_regs", q, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_mask();
      logic [31:0] q;
      logic a;
      wr(7'h2c, 8'h76, 32'hefffffff, 4, a);
      chk("ack_burst", a, 1'b1);
      put(8'h75, 8'ha5);
      rd(7'h2c, 8'h75, 1, q);
      chk("unmapped", q, 32'h0);
      rd(7'h2c, 8'h76, 4, q);
      chk("readback", q, 32'hefff7733);
      outs(1800, 300, 260, 600, 500);
      chk("slew_off", slowed_slew_code, 2'h0);
      wr(7'h2c, 8'h76, 32'h0, 4, a);
      $display("test mask done");
   endtask

   task automatic t_fields();
      logic [7:0] v6, v8, v9;
      logic a;
      for (int i = 0; i < 8; i++) begin
         v6 = {i[2], 5'h00, i[1:0]};
         v8 = {1'b0, i[2:0], 1'b0, i[2:0]};
         v9 = {2'h0, i[1:0], 2'h0, i[1:0]};
         wr(7'h2c, 8'h76, {v6, 8'h00, v8, v9}, 4, a);
         outs(i[2] ? pk_h[i[1:0]] : pk_n[i[1:0]],
              slope[i], 50 + 30 * i, hyst[i[1:0]], range[i[1:0]]);
      end
      $display("test fields done");
   endtask

   task automatic t_slew();
      for (int c = 0; c < 4; c++) begin
         put(8'h76, {4'h0, c[1:0], 2'h0});
         @(posedge sys_clk) slew_limit_enable <= 1'b1;
         repeat (3) @(posedge sys_clk);
         @(negedge sys_clk);
         chk("slew_on", slowed_slew_code, c[1:0]);
         @(posedge sys_clk) slew_limit_enable <= 1'b0;
         repeat (3) @(posedge sys_clk);
         @(negedge sys_clk);
         chk("slew_off", slowed_slew_code, 2'h0);
      end
      put(8'h76, 8'h00);
      $display("test slew done");
   endtask

   task automatic t_alt();
      logic [31:0] q;
      logic a;
      put(8'h76, 8'h10);
      wr(7'h2c, 8'h77, 32'h40000000, 1, a);
      chk("nack_2c", a, 1'b0);
      rd(7'h2e, 8'h76, 2, q);
      chk("alt_read", q, 32'h1000);
      wr(7'h2e, 8'h76, 32'h0, 1, a);
      chk("ack_2e", a, 1'b1);
      put(8'h76, 8'h00);
      $display("test alt done");
   endtask

   task automatic tick();
      @(posedge sys_clk) boost_tick <= 1'b1;
      @(posedge sys_clk) boost_tick <= 1'b0;
      @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   task automatic t_mod();
      int m0, n;
      for (int c = 0; c < 4; c++) begin
         put(8'h77, {c[1:0], 6'h00});
         for (int p = 0; p < 2; p++) begin
            m0 = mod_cnt;
            n = 0;
            while (mod_cnt == m0 && n < 900) begin
               tick();
               n++;
            end
         end
         chk("mod_period", n, period[c]);
      end
      $display("test modulation done");
   endtask

   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      @(negedge sys_clk);
      t_reset();
      t_mask();
      t_fields();
      t_slew();
      t_alt();
      t_mod();
      close_out();
   end
endmodule
